// ---- cmc_pkg.sv ----
`default_nettype none
package cmc_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] RUN_SPEED_OFS = 6'h04;
  localparam logic [5:0] INIT_SPEED_OFS = 6'h08;
  localparam logic [5:0] ACCEL_TIME_OFS = 6'h0c;
  localparam logic [5:0] DECEL_TIME_OFS = 6'h10;
  localparam logic [5:0] STATUS_OFS = 6'h14;
  localparam logic [5:0] SPEED_OFS = 6'h18;
  localparam logic [5:0] ALARM_OFS = 6'h1c;
  localparam logic [5:0] INT_STATUS_OFS = 6'h20;
  localparam logic [5:0] INT_MASK_OFS = 6'h24;
  // command register bit positions (write-only strobes)
  localparam int CTRL_POS_BIT = 0;
  localparam int CTRL_NEG_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_WAIT_BIT = 3;
  localparam int CTRL_SEQ_BIT = 4;
  localparam int CTRL_ALM_CLR_BIT = 5;
  // interrupt status bit positions
  localparam int INT_END_BIT = 0;
  localparam int INT_REJECT_BIT = 1;
  localparam int INT_ALARM_BIT = 2;
  localparam int INT_WAIT_BIT = 3;
  // alarm codes
  localparam logic [7:0] ALARM_NONE = 8'h00;
  localparam logic [7:0] ALARM_CMD = 8'ha0;
  localparam logic [7:0] ALARM_NO_END = 8'h6f;
  // reset values of the settings
  localparam logic [15:0] RUN_SPEED_RST = 16'h0064;
  localparam logic [15:0] INIT_SPEED_RST = 16'h000a;
  localparam logic [15:0] RAMP_TIME_RST = 16'h0000;
  // timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int END_WAIT_NS = 10000000;
  localparam int END_WAIT_CYCLES = END_WAIT_NS / CLK_NS;
  // motion states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RAMP = 4'h2,
    ST_RUN = 4'h4,
    ST_STOP = 4'h8
  } motion_state_e;
endpackage : cmc_pkg
`default_nettype wire

// ---- continuous_move_control.sv ----
// Contract
// - positive/negative command starts open-ended motion
// - start at initial speed, ramp to running
// - run until stop or alarm
// - same-direction reissue re-speeds without stopping
// - opposite direction rejected: error or A0h
// - reject if busy, current off, alarm
// - connector and remote I/O also start motion
// - command returns at once, others refused
// - motion active and motion finished statuses
// - wait command holds sequence until done
// - wait with no motion proceeds immediately
// - missing end signal while waiting: 6Fh
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module continuous_move_control #(
  parameter int END_WAIT = cmc_pkg::END_WAIT_CYCLES // driver end timeout, cycles
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic io_cont_pos, // connector input, one-cycle pulse
  input wire logic io_cont_neg,
  input wire logic rio_cont_pos, // remote i/o bit, one-cycle pulse
  input wire logic rio_cont_neg,
  input wire logic stop_in, // stop request pulse
  input wire logic motor_current_on,
  input wire logic other_motion_busy, // positioning or homing in progress
  input wire logic drv_end_in, // end signal from the driver
  output logic motion_active_flag,
  output logic motion_finished_flag,
  output logic move_dir, // 1 = negative
  output logic [15:0] speed_out,
  output logic seq_hold,
  output logic irq
);
  cmc_pkg::motion_state_e state_reg; // motion state
  logic ack_reg; // wishbone ack
  logic [31:0] rdata_reg; // read data
  logic [15:0] run_speed_reg; // running speed setting
  logic [15:0] init_speed_reg; // initial speed setting
  logic [15:0] accel_time_reg; // ticks per speed step up, less one
  logic [15:0] decel_time_reg; // ticks per speed step down, less one
  logic [15:0] speed_reg; // present speed
  logic [15:0] target_reg; // speed the ramp heads for
  logic [15:0] ramp_cnt_reg; // ticks since last step
  logic [7:0] tick_cnt_reg; // tick divider
  logic [7:0] alarm_code_reg; // latched alarm code
  logic [3:0] int_status_reg; // sticky events
  logic [3:0] int_mask_reg; // interrupt enables
  logic dir_reg; // direction of present motion
  logic finished_reg; // motion finished status
  logic waiting_reg; // sequence held on wait
  logic [31:0] end_cnt_reg; // cycles waited for driver end
  logic tick; // ramp time base pulse
  logic wr_en; // bus write taken this cycle
  logic cmd_wr; // command register write
  logic seq_src; // command came from a sequence
  logic pos_req, neg_req, cmd_req, cmd_neg;
  logic cmd_ok, cmd_accept, cmd_start, cmd_respeed, cmd_reject;
  logic stop_req, wait_req, alarm_clr, alarm_act;
  logic end_ev, end_timeout, step_due;
  logic [3:0] ev_set; // events this cycle

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
  assign cmd_wr = wr_en && wb_adr_i == cmc_pkg::CTRL_OFS && wb_sel_i[0];
  assign seq_src = cmd_wr && wb_dat_i[cmc_pkg::CTRL_SEQ_BIT];
  // bus, connector and remote i/o all feed the same command path
  assign pos_req = (cmd_wr && wb_dat_i[cmc_pkg::CTRL_POS_BIT]) || io_cont_pos
    || rio_cont_pos;
  assign neg_req = (cmd_wr && wb_dat_i[cmc_pkg::CTRL_NEG_BIT]) || io_cont_neg
    || rio_cont_neg;
  assign cmd_req = pos_req || neg_req;
  assign cmd_neg = !pos_req; // positive wins when both arrive together
  assign stop_req = (cmd_wr && wb_dat_i[cmc_pkg::CTRL_STOP_BIT]) || stop_in;
  assign wait_req = cmd_wr && wb_dat_i[cmc_pkg::CTRL_WAIT_BIT];
  assign alarm_clr = cmd_wr && wb_dat_i[cmc_pkg::CTRL_ALM_CLR_BIT];
  assign alarm_act = alarm_code_reg != cmc_pkg::ALARM_NONE;
  // a command is legal only with current on, no alarm, no other motion
  assign cmd_ok = motor_current_on && !alarm_act && !other_motion_busy;
  assign cmd_start = cmd_req && cmd_ok && state_reg == cmc_pkg::ST_IDLE;
  // same direction while running or ramping only changes speed
  assign cmd_respeed = cmd_req && cmd_ok && cmd_neg == dir_reg
    && (state_reg == cmc_pkg::ST_RAMP || state_reg == cmc_pkg::ST_RUN);
  assign cmd_accept = cmd_start || cmd_respeed;
  // opposite direction or a stopping motion counts as a refused command
  assign cmd_reject = cmd_req && !cmd_accept;
  assign end_ev = state_reg == cmc_pkg::ST_STOP && speed_reg <= init_speed_reg;
  assign end_timeout = waiting_reg && !motion_active_flag && !drv_end_in
    && end_cnt_reg >= END_WAIT - 1;
  assign step_due = tick && ramp_cnt_reg >= (speed_reg < target_reg
    ? accel_time_reg : decel_time_reg);

  // one-cycle ack; a sequence write therefore never waits for motion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // read mux, registered with the ack; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      unique case (wb_adr_i)
        cmc_pkg::RUN_SPEED_OFS: rdata_reg <= {16'h0, run_speed_reg};
        cmc_pkg::INIT_SPEED_OFS: rdata_reg <= {16'h0, init_speed_reg};
        cmc_pkg::ACCEL_TIME_OFS: rdata_reg <= {16'h0, accel_time_reg};
        cmc_pkg::DECEL_TIME_OFS: rdata_reg <= {16'h0, decel_time_reg};
        cmc_pkg::STATUS_OFS: rdata_reg <= {27'h0, alarm_act, waiting_reg,
          dir_reg, finished_reg, motion_active_flag};
        cmc_pkg::SPEED_OFS: rdata_reg <= {16'h0, speed_reg};
        cmc_pkg::ALARM_OFS: rdata_reg <= {24'h0, alarm_code_reg};
        cmc_pkg::INT_STATUS_OFS: rdata_reg <= {28'h0, int_status_reg};
        cmc_pkg::INT_MASK_OFS: rdata_reg <= {28'h0, int_mask_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  // speed and time settings; low two byte lanes only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_speed_reg <= cmc_pkg::RUN_SPEED_RST;
      init_speed_reg <= cmc_pkg::INIT_SPEED_RST;
      accel_time_reg <= cmc_pkg::RAMP_TIME_RST;
      decel_time_reg <= cmc_pkg::RAMP_TIME_RST;
      int_mask_reg <= 4'h0;
    end else if (wr_en && wb_sel_i[1:0] == 2'h3) begin
      unique case (wb_adr_i)
        cmc_pkg::RUN_SPEED_OFS: run_speed_reg <= wb_dat_i[15:0];
        cmc_pkg::INIT_SPEED_OFS: init_speed_reg <= wb_dat_i[15:0];
        cmc_pkg::ACCEL_TIME_OFS: accel_time_reg <= wb_dat_i[15:0];
        cmc_pkg::DECEL_TIME_OFS: decel_time_reg <= wb_dat_i[15:0];
        cmc_pkg::INT_MASK_OFS: int_mask_reg <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // ramp time base: one tick per microsecond
  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      tick_cnt_reg <= 8'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h1;
    end
  end
  assign tick = tick_cnt_reg == 8'(cmc_pkg::TICK_CYCLES - 1);

  // motion state, direction, speed and ramp
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= cmc_pkg::ST_IDLE;
      dir_reg <= 1'b0;
      speed_reg <= 16'h0;
      target_reg <= 16'h0;
      ramp_cnt_reg <= 16'h0;
    end else if (alarm_act) begin
      // an alarm ends motion at once, no ramp
      state_reg <= cmc_pkg::ST_IDLE;
      speed_reg <= 16'h0;
    end else if (cmd_start) begin
      state_reg <= cmc_pkg::ST_RAMP;
      dir_reg <= cmd_neg;
      speed_reg <= init_speed_reg;
      target_reg <= run_speed_reg;
      ramp_cnt_reg <= 16'h0;
    end else if (cmd_respeed) begin
      state_reg <= cmc_pkg::ST_RAMP;
      target_reg <= run_speed_reg;
      // a stale count would cut the first step of the new ramp short
      ramp_cnt_reg <= 16'h0;
    end else if (stop_req && state_reg != cmc_pkg::ST_IDLE) begin
      state_reg <= cmc_pkg::ST_STOP;
      target_reg <= init_speed_reg;
      // first step down keeps the full deceleration spacing
      ramp_cnt_reg <= 16'h0;
    end else begin
      unique case (state_reg)
        cmc_pkg::ST_IDLE: speed_reg <= 16'h0;
        cmc_pkg::ST_RUN: ; // holds speed with no end of its own
        cmc_pkg::ST_RAMP, cmc_pkg::ST_STOP: begin
          if (end_ev) begin
            state_reg <= cmc_pkg::ST_IDLE;
            speed_reg <= 16'h0;
          end else if (state_reg == cmc_pkg::ST_RAMP && speed_reg == target_reg) begin
            state_reg <= cmc_pkg::ST_RUN;
          end else if (step_due) begin
            // speed steps by one every programmed tick count plus one
            ramp_cnt_reg <= 16'h0;
            speed_reg <= speed_reg < target_reg ? speed_reg + 16'h1
              : speed_reg - 16'h1;
          end else if (tick) begin
            ramp_cnt_reg <= ramp_cnt_reg + 16'h1;
          end
        end
      endcase
    end
  end
  assign motion_active_flag = state_reg != cmc_pkg::ST_IDLE;
  assign move_dir = dir_reg;
  assign speed_out = speed_reg;

  // finished status: cleared on start, set once motion has wound down
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      finished_reg <= 1'b1;
    end else if (cmd_start) begin
      finished_reg <= 1'b0;
    end else if (end_ev || (alarm_act && motion_active_flag)) begin
      finished_reg <= 1'b1;
    end
  end
  assign motion_finished_flag = finished_reg;

  // sequence hold and driver end watch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waiting_reg <= 1'b0;
      end_cnt_reg <= 32'h0;
    end else if (wait_req) begin
      // with no motion the sequence is never held
      waiting_reg <= motion_active_flag;
      end_cnt_reg <= 32'h0;
    end else if (waiting_reg && !motion_active_flag) begin
      end_cnt_reg <= end_cnt_reg + 32'h1;
      if (drv_end_in || end_timeout) begin
        waiting_reg <= 1'b0;
      end
    end
  end
  assign seq_hold = waiting_reg;

  // alarm code: first alarm wins until cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarm_code_reg <= cmc_pkg::ALARM_NONE;
    end else if (!alarm_act && cmd_reject && seq_src) begin
      alarm_code_reg <= cmc_pkg::ALARM_CMD;
    end else if (!alarm_act && end_timeout) begin
      alarm_code_reg <= cmc_pkg::ALARM_NO_END;
    end else if (alarm_clr) begin
      alarm_code_reg <= cmc_pkg::ALARM_NONE;
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign ev_set = {wait_req && !motion_active_flag || waiting_reg && !motion_active_flag
    && drv_end_in, (cmd_reject && seq_src) || end_timeout,
    cmd_reject && !seq_src, end_ev};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_status_reg <= 4'h0;
    end else begin
      int_status_reg <= (int_status_reg & ~((wr_en && wb_sel_i[0]
        && wb_adr_i == cmc_pkg::INT_STATUS_OFS) ? wb_dat_i[3:0] : 4'h0)) | ev_set;
    end
  end
  assign irq = |(int_status_reg & int_mask_reg);

  // checks
  sequence start_pos_s;
    cmd_start && !cmd_neg && !alarm_act;
  endsequence
  sequence seq_reject_s;
    cmd_reject && seq_src && !alarm_act;
  endsequence
  start_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_pos_s |=> motion_active_flag && !move_dir)
    else $error("positive start did not move positive");
  start_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_start && !alarm_act |=> speed_out == $past(init_speed_reg))
    else $error("start speed is not the initial speed");
  run_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == cmc_pkg::ST_RUN && !stop_req && !alarm_act && !cmd_req
    |=> state_reg == cmc_pkg::ST_RUN)
    else $error("running motion ended by itself");
  respeed_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_respeed && !alarm_act |=> motion_active_flag && target_reg == $past(run_speed_reg))
    else $error("reissue did not re-speed");
  opp_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    seq_reject_s |=> alarm_code_reg == cmc_pkg::ALARM_CMD)
    else $error("sequence reject raised no A0h");
  off_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_req && !motor_current_on && !motion_active_flag && !alarm_act
    |=> !motion_active_flag)
    else $error("motion started with current off");
  io_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    io_cont_neg && !pos_req && cmd_ok && !motion_active_flag
    |=> motion_active_flag && move_dir)
    else $error("connector input did not start motion");
  bus_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("command write not acked at once");
  flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    motion_active_flag |-> !motion_finished_flag || $past(alarm_act))
    else $error("finished shown while moving");
  hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    wait_req && motion_active_flag |=> seq_hold [*2])
    else $error("wait did not hold the sequence");
  no_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    wait_req && !motion_active_flag |=> !seq_hold)
    else $error("wait held with no motion");
  end_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    end_timeout && !alarm_act |=> alarm_code_reg == cmc_pkg::ALARM_NO_END && !seq_hold)
    else $error("missing end raised no 6Fh");
  decel_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == cmc_pkg::ST_STOP && speed_reg > init_speed_reg && !alarm_act
    |=> !motion_finished_flag)
    else $error("finished before ramp down");
endmodule : continuous_move_control
`default_nettype wire

// ---- cmc_driver_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// stands in for the motor driver: reports end of travel once the motion settles
module cmc_driver_model #(
  parameter int SETTLE = 3 // cycles from motion stop to end report
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic motion_active_flag,
  input wire logic end_ok, // low makes the driver withhold its end signal
  output logic drv_end_in
);
  int settle_cnt; // cycles since the motion stopped
  // the end report never rises with the motion edge itself, only after settling
  always_ff @(posedge clk) begin
    if (!rst_n || motion_active_flag) begin
      settle_cnt <= 0;
    end else if (settle_cnt < SETTLE) begin
      settle_cnt <= settle_cnt + 1;
    end
  end
  assign drv_end_in = end_ok && !motion_active_flag && (settle_cnt == SETTLE);
endmodule : cmc_driver_model
`default_nettype wire

// ---- continuous_move_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module continuous_move_control_tb;
  localparam logic [5:0] A_CTRL = cmc_pkg::CTRL_OFS;
  localparam logic [5:0] A_STAT = cmc_pkg::STATUS_OFS;
  localparam logic [5:0] A_INT = cmc_pkg::INT_STATUS_OFS;
  localparam logic [5:0] A_ALM = cmc_pkg::ALARM_OFS;
  localparam logic [5:0] A_RUN = cmc_pkg::RUN_SPEED_OFS;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r, q; // q holds the last read
  logic ack, active, finished, dir, hold, irq, drv_end;
  logic [15:0] speed;
  logic [4:0] pins = 5'h00; // io pos, io neg, rio pos, rio neg, stop
  logic cur_on = 1'b1, busy = 1'b0, end_ok = 1'b1;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  int step_gap = 0; // cycles from a ramp's start to its first speed step
  // short end timeout keeps the missing-end case quick
  continuous_move_control #(.END_WAIT(20)) i_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .io_cont_pos(pins[0]), .io_cont_neg(pins[1]), .rio_cont_pos(pins[2]),
    .rio_cont_neg(pins[3]), .stop_in(pins[4]), .motor_current_on(cur_on),
    .other_motion_busy(busy), .drv_end_in(drv_end), .motion_active_flag(active),
    .motion_finished_flag(finished), .move_dir(dir), .speed_out(speed),
    .seq_hold(hold), .irq(irq));
  cmc_driver_model i_drv (.clk(clk), .rst_n(rst_n), .motion_active_flag(active),
    .end_ok(end_ok), .drv_end_in(drv_end));
  always #5 clk = ~clk;
  // hang guard: far above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one classic cycle: request held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string n, input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rd
  // one-cycle pulse on the connector, remote and stop pins
  task automatic kick(input logic [4:0] m);
    @(posedge clk);
    pins <= m;
    @(posedge clk);
    pins <= 5'h00;
  endtask : kick
  // bounded waits: with one tick of ramp time the speed moves one unit every two microsecond ticks
  task automatic wait_speed(input logic [15:0] s);
    int k = 0;
    while (speed !== s && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk("speed", {16'h0, s}, {16'h0, speed});
  endtask : wait_speed
  task automatic wait_low(input string n, ref logic s);
    int k = 0;
    while (s !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(n, 32'h0, {31'h0, s});
  endtask : wait_low
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd("status", A_STAT, 32'h2);
    rd("run", A_RUN, {16'h0, cmc_pkg::RUN_SPEED_RST});
    rd("unmapped", 6'h3c, 32'h0);
    wr(A_RUN, 32'hc);
    wr(cmc_pkg::ACCEL_TIME_OFS, 32'h1);
    wr(cmc_pkg::DECEL_TIME_OFS, 32'h1);
    rd("accel", cmc_pkg::ACCEL_TIME_OFS, 32'h1);
    wr(cmc_pkg::INT_MASK_OFS, 32'h2);
    rd("mask", cmc_pkg::INT_MASK_OFS, 32'h2);
    wr(A_CTRL, 32'h1);
    chk("start", {16'h0, cmc_pkg::INIT_SPEED_RST}, {16'h0, speed});
    // one tick of accel time: first step lands two ticks after the start
    step_gap = 0;
    while (speed == cmc_pkg::INIT_SPEED_RST && step_gap < 400) begin
      @(posedge clk);
      step_gap++;
    end
    chk("accel gap", 32'h1, {31'h0, (step_gap > 100 && step_gap <= 200)});
    rd("pos", A_STAT, 32'h1);
    wait_speed(16'hc);
    wr(A_RUN, 32'he);
    wr(A_CTRL, 32'h1);
    wait_speed(16'he);
    repeat (400) @(posedge clk);
    rd("running", A_STAT, 32'h1);
    rd("speed reg", cmc_pkg::SPEED_OFS, 32'he);
    wr(A_CTRL, 32'h2);
    rd("dir kept", A_STAT, 32'h1);
    rd("reject", A_INT, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(A_INT, 32'h2);
    chk("irq clr", 32'h0, {31'h0, irq});
    wr(A_CTRL, 32'h18);
    wr(A_CTRL, 32'h4);
    // one tick of decel time: first step down two ticks after the stop
    step_gap = 0;
    while (speed == 16'he && step_gap < 400) begin
      @(posedge clk);
      step_gap++;
    end
    chk("decel gap", 32'h1, {31'h0, (step_gap > 100 && step_gap <= 200)});
    rd("stopping", A_STAT, 32'h9);
    wr(A_CTRL, 32'h1);
    rd("stop refused", A_STAT, 32'h9);
    chk("irq refused", 32'h1, {31'h0, irq});
    wait_low("active", active);
    chk("finished", 32'h1, {31'h0, finished});
    wait_low("hold", hold);
    rd("ends", A_INT, 32'hb);
    wr(A_INT, 32'hf);
    wr(A_CTRL, 32'h18);
    chk("no hold", 32'h0, {31'h0, hold});
    rd("wait idle", A_INT, 32'h8);
    kick(5'h02);
    rd("io neg", A_STAT, 32'h5);
    chk("dir", 32'h1, {31'h0, dir});
    kick(5'h04);
    rd("rio pos", A_STAT, 32'h5);
    kick(5'h10);
    wait_low("io stop", active);
    kick(5'h08);
    rd("rio neg", A_STAT, 32'h5);
    kick(5'h10);
    wait_low("rio stop", active);
    kick(5'h01);
    rd("io pos", A_STAT, 32'h1);
    kick(5'h10);
    wait_low("pos stop", active);
    wr(A_INT, 32'hf);
    cur_on <= 1'b0;
    wr(A_CTRL, 32'h1);
    rd("cur off", A_STAT, 32'h2);
    rd("cur int", A_INT, 32'h2);
    cur_on <= 1'b1;
    busy <= 1'b1;
    wr(A_CTRL, 32'h11);
    busy <= 1'b0;
    rd("busy alm", A_ALM, 32'ha0);
    rd("alm int", A_INT, 32'h6);
    wr(A_CTRL, 32'h1);
    rd("in alarm", A_STAT, 32'h12);
    wr(A_CTRL, 32'h20);
    rd("alm clr", A_ALM, 32'h0);
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h12);
    rd("opp alm", A_ALM, 32'ha0);
    rd("alm stop", A_STAT, 32'h12);
    wr(A_CTRL, 32'h20);
    end_ok <= 1'b0;
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h18);
    wr(A_CTRL, 32'h4);
    wait_low("no end", hold);
    rd("end alm", A_ALM, 32'h6f);
    end_ok <= 1'b1;
    wr(A_CTRL, 32'h20);
    end_sim();
  end
endmodule : continuous_move_control_tb
`default_nettype wire
